/* File: inc/drils_pkg.sv */
// Package with register map, field positions and codes for the request and level select block
package drils_pkg;
    // ==================== Register offsets
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] IEN_OFF = 8'h08;
    localparam logic [7:0] ICLR_OFF = 8'h0c;
    localparam logic [7:0] LVL_OFF = 8'h10;
    // ==================== Command word fields
    localparam int MODE_LSB = 8;
    localparam int MODE_W = 6;
    localparam int OUT1_EN_BIT = 5;
    localparam int OUT0_EN_BIT = 4;
    localparam int SENSE_DRV_BIT = 3;
    localparam int LVL_LSB = 0;
    localparam int LVL_W = 3;
    localparam logic [15:0] CMD_RST = 16'h0000;
    // ==================== Status bits
    localparam int ST_OUT0 = 0;
    localparam int ST_OUT1 = 1;
    localparam int ST_TIMER = 2;
    localparam int ST_ADC = 3;
    localparam int NUM_EV = 4;
    localparam logic [3:0] IEN_RST = 4'h0;
    // ==================== Mode patterns
    localparam logic [5:0] MODE_ADC_AB = 6'h3c;
    localparam logic [5:0] MODE_A_OUT0 = 6'h3d;
    localparam logic [5:0] MODE_A_OUT1 = 6'h3e;
    localparam logic [5:0] MODE_A_BOTH = 6'h3f;
    // ==================== Host interrupt levels by code
    localparam int NUM_LINES = 16;
    localparam logic [3:0] LVL_MAP [8] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'ha, 4'hb, 4'hc, 4'hf};
endpackage : drils_pkg

/* File: hw/drils_sync.sv */
// Three-stage synchroniser for a pin input, change counted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module drils_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    logic [W-1:0] outQ;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1Q <= '0;
            s2Q <= '0;
            s3Q <= '0;
            outQ <= '0;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            for (int i = 0; i < W; i++) begin
                if (s2Q[i] == s3Q[i]) begin
                    outQ[i] <= s3Q[i];
                end
            end
        end
    end

    assign dout = outQ;
endmodule : drils_sync
`default_nettype wire

/* File: hw/drils_route.sv */
// Combinational decode of the six-bit mode pattern into DMA channel sources and sinks
`timescale 1ns/100ps
`default_nettype none
module drils_route (
    input wire logic [5:0] mode,
    input wire logic [1:0] outReady,
    input wire logic adcReady,
    input wire logic timerTick,
    input wire logic interleaveSel,
    output logic reqA,
    output logic reqB,
    output logic timerIrq,
    output logic adcIrq
);
    always_comb begin
        reqA = 1'b0;
        reqB = 1'b0;
        timerIrq = 1'b0;
        adcIrq = 1'b0;
        unique case (mode)
            drils_pkg::MODE_ADC_AB: begin
                // Double-buffered: both channels serve the input converter
                reqA = adcReady & ~interleaveSel;
                reqB = adcReady & interleaveSel;
                timerIrq = timerTick;
            end
            drils_pkg::MODE_A_OUT0: begin
                reqA = outReady[0];
                reqB = adcReady;
            end
            drils_pkg::MODE_A_OUT1: begin
                reqA = outReady[1];
                reqB = adcReady;
            end
            drils_pkg::MODE_A_BOTH: begin
                // Interleaved: alternate converter takes each A request
                reqA = interleaveSel ? outReady[1] : outReady[0];
                reqB = adcReady;
            end
            default: begin
                adcIrq = adcReady;
            end
        endcase
    end
endmodule : drils_route
`default_nettype wire

/* File: hw/drils_top.sv */
// Output request enables, sense line drive, host interrupt level select and DMA routing
// ====================
`timescale 1ns/100ps
`default_nettype none
module drils_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nonref_single_ended_cfg,
    input wire logic out0Ready,
    input wire logic out1Ready,
    input wire logic adcReady,
    input wire logic timerTick,
    input wire logic analogSenseIn,
    output logic analogSenseOut,
    output logic analogSenseOe_b,
    output logic [15:0] hostIrqLines,
    output logic dmaReqA,
    output logic dmaReqB,
    output logic irq
);
    // ==================== State
    typedef struct packed {
        logic [15:0] cmd;
        logic [3:0] stat;
        logic [3:0] ien;
        logic [1:0] outPrev;
        logic adcPrev;
        logic tickPrev;
        logic interleave;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic senseOe_b;
        logic [15:0] lines;
        logic reqA;
        logic reqB;
        logic irq;
    } drils_state_s;

    drils_state_s st_q;
    drils_state_s st_d;

    // ==================== Pin synchronisers
    logic [4:0] pinsRaw;
    logic [4:0] pinsSync;
    assign pinsRaw = {nonref_single_ended_cfg, out0Ready, out1Ready, adcReady, timerTick};

    drils_sync #(.W(5)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .din(pinsRaw),
        .dout(pinsSync)
    );

    logic nrseS;
    logic out0S;
    logic out1S;
    logic adcS;
    logic tickS;
    assign nrseS = pinsSync[4];
    assign out0S = pinsSync[3];
    assign out1S = pinsSync[2];
    assign adcS = pinsSync[1];
    assign tickS = pinsSync[0];

    // ==================== Field decode
    logic out1En;
    logic out0En;
    logic senseDrv;
    logic [5:0] modeSel;
    logic [2:0] lvlCode;
    assign out1En = st_q.cmd[drils_pkg::OUT1_EN_BIT];
    assign out0En = st_q.cmd[drils_pkg::OUT0_EN_BIT];
    assign senseDrv = st_q.cmd[drils_pkg::SENSE_DRV_BIT];
    assign modeSel = st_q.cmd[drils_pkg::MODE_LSB +: drils_pkg::MODE_W];
    assign lvlCode = st_q.cmd[drils_pkg::LVL_LSB +: drils_pkg::LVL_W];

    // Rising edges of ready strobes
    logic out0Rise;
    logic out1Rise;
    logic adcRise;
    logic tickRise;
    assign out0Rise = out0S & ~st_q.outPrev[0];
    assign out1Rise = out1S & ~st_q.outPrev[1];
    assign adcRise = adcS & ~st_q.adcPrev;
    assign tickRise = tickS & ~st_q.tickPrev;

    // Output converter readiness only counts while its enable is set
    logic [1:0] outGated;
    assign outGated[0] = out0Rise & out0En;
    assign outGated[1] = out1Rise & out1En;

    logic rA;
    logic rB;
    logic tIrq;
    logic aIrq;

    drils_route u_route (
        .mode(modeSel),
        .outReady(outGated),
        .adcReady(adcRise),
        .timerTick(tickRise),
        .interleaveSel(st_q.interleave),
        .reqA(rA),
        .reqB(rB),
        .timerIrq(tIrq),
        .adcIrq(aIrq)
    );

    function automatic logic [15:0] lvl_onehot(input logic [2:0] code, input logic on);
        logic [15:0] v;
        v = '0;
        v[drils_pkg::LVL_MAP[code]] = on;
        return v;
    endfunction : lvl_onehot

    // ==================== Next state
    logic apbAcc;
    logic apbWr;
    logic apbRd;
    logic addrOk;
    logic [3:0] evSet;
    logic [3:0] clrMask;

    always_comb begin
        st_d = st_q;
        apbAcc = psel & penable & ~st_q.ready;
        apbWr = apbAcc & pwrite;
        apbRd = apbAcc & ~pwrite;
        addrOk = (paddr == drils_pkg::CMD_OFF) || (paddr == drils_pkg::STAT_OFF)
            || (paddr == drils_pkg::IEN_OFF) || (paddr == drils_pkg::ICLR_OFF)
            || (paddr == drils_pkg::LVL_OFF);
        clrMask = '0;
        st_d.ready = apbAcc;
        st_d.err = apbAcc & ~addrOk;
        st_d.rdata = '0;
        if (apbWr) begin
            unique case (paddr)
                drils_pkg::CMD_OFF: st_d.cmd = pwdata[15:0];
                drils_pkg::IEN_OFF: st_d.ien = pwdata[3:0];
                drils_pkg::ICLR_OFF: clrMask = pwdata[3:0];
                default: ;
            endcase
        end
        if (apbRd) begin
            unique case (paddr)
                drils_pkg::CMD_OFF: st_d.rdata = {16'h0000, st_q.cmd};
                drils_pkg::STAT_OFF: st_d.rdata = {28'h0000000, st_q.stat};
                drils_pkg::IEN_OFF: st_d.rdata = {28'h0000000, st_q.ien};
                drils_pkg::LVL_OFF: st_d.rdata = {16'h0000, st_q.lines};
                default: st_d.rdata = '0;
            endcase
        end
        st_d.outPrev = {out1S, out0S};
        st_d.adcPrev = adcS;
        st_d.tickPrev = tickS;
        if (rA && modeSel == drils_pkg::MODE_A_BOTH) begin
            st_d.interleave = ~st_q.interleave;
        end
        if ((rA || rB) && modeSel == drils_pkg::MODE_ADC_AB) begin
            st_d.interleave = ~st_q.interleave;
        end
        // Set beats clear in the same cycle
        evSet = '0;
        evSet[drils_pkg::ST_OUT0] = outGated[0];
        evSet[drils_pkg::ST_OUT1] = outGated[1];
        evSet[drils_pkg::ST_TIMER] = tIrq;
        evSet[drils_pkg::ST_ADC] = aIrq;
        st_d.stat = (st_q.stat & ~clrMask) | evSet;
        st_d.reqA = rA;
        st_d.reqB = rB;
        st_d.irq = |(st_d.stat & st_d.ien);
        // Nonref single-ended always wins: line stays an input
        st_d.senseOe_b = ~(senseDrv & ~nrseS);
        st_d.lines = lvl_onehot(lvlCode, st_d.irq);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.cmd <= drils_pkg::CMD_RST;
            st_q.ien <= drils_pkg::IEN_RST;
            st_q.senseOe_b <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================== Outputs
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.err;
    // Grounding only: driven value is always zero
    assign analogSenseOut = 1'b0;
    assign analogSenseOe_b = st_q.senseOe_b;
    assign hostIrqLines = st_q.lines;
    assign dmaReqA = st_q.reqA;
    assign dmaReqB = st_q.reqB;
    assign irq = st_q.irq;

    logic unusedSense;
    assign unusedSense = analogSenseIn;
endmodule : drils_top
`default_nettype wire

/* File: tb/drils_monitor.sv */
// Checker on the top-level ports of the request and level select block
`timescale 1ns/100ps
`default_nettype none
module drils_monitor (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nonref_single_ended_cfg,
    input wire logic analogSenseOut,
    input wire logic analogSenseOe_b,
    input wire logic [15:0] hostIrqLines,
    input wire logic dmaReqA,
    input wire logic dmaReqB,
    input wire logic irq
);
    logic [2:0] cfgRun_q;
    logic [2:0] cfgRun_d;
    // Saturates, so the synchroniser delay is long past before we judge the pin
    always_comb cfgRun_d = !nonref_single_ended_cfg ? 3'h0 : cfgRun_q + 3'(cfgRun_q != 3'h7);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfgRun_q <= 3'h0;
        end else begin
            cfgRun_q <= cfgRun_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ==========
    // Assertions
    ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
    ready_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("late pready");
    err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
    sense_ground_a: assert property (!analogSenseOe_b |-> !analogSenseOut)
        else $error("sense not grounded");
    sense_input_a: assert property (cfgRun_q == 3'h7 |-> analogSenseOe_b)
        else $error("sense driven in nonref");
    level_follow_a: assert property ((|hostIrqLines) == irq && $onehot0(hostIrqLines))
        else $error("level lines off");
    level_set_a: assert property ((hostIrqLines & 16'h6347) == 16'h0000)
        else $error("bad level line");
    dma_a_pulse_a: assert property (dmaReqA |=> !dmaReqA) else $error("long A");
    dma_b_pulse_a: assert property (dmaReqB |=> !dmaReqB) else $error("long B");
    cov_a: cover property (dmaReqA);
    cov_b: cover property (dmaReqB);
    cov_err: cover property (pslverr);
    cov_irq: cover property ($rose(irq));
endmodule : drils_monitor
bind drils_top drils_monitor mon (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .nonref_single_ended_cfg(nonref_single_ended_cfg),
    .analogSenseOut(analogSenseOut), .analogSenseOe_b(analogSenseOe_b),
    .hostIrqLines(hostIrqLines), .dmaReqA(dmaReqA), .dmaReqB(dmaReqB), .irq(irq));
`default_nettype wire

/* File: tb/drils_host.sv */
// Host DMA controller model counting requests on both channels
`timescale 1ns/100ps
`default_nettype none
module drils_host (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic dmaReqA,
    input wire logic dmaReqB,
    output var int cntA,
    output var int cntB
);
    // ==========
    // Grants every request at once, so only the count matters
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cntA <= 0;
            cntB <= 0;
        end else begin
            cntA <= cntA + int'(dmaReqA);
            cntB <= cntB + int'(dmaReqB);
        end
    end
endmodule : drils_host
`default_nettype wire

/* File: tb/dac_request_irq_level_select_tb.sv */
// Self-checking bench for request enables, sense drive, level select and routing
`timescale 1ns/100ps
`default_nettype none
module dac_request_irq_level_select_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cfg = 1'b0, perr, senseIn;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cmd, ev;
    logic pready, pslverr, senseOut, senseOe_b, dmaA, dmaB, irq;
    logic [3:0] evLvl = 4'h0; // adc, timer, out1, out0
    logic [15:0] lines;
    int errors = 0, checks = 0, cntA, cntB, exA, exB;
    int lvMap [8] = '{3, 4, 5, 7, 10, 11, 12, 15};
    int modes [4] = '{'h3c, 'h3d, 'h3e, 'h3f};
    int expA [4] = '{1, 1, 1, 2};
    int expB [4] = '{1, 2, 2, 2};
    always #25 clock = ~clock;
    // Released line must not look stable
    assign senseIn = senseOe_b ? clock : senseOut;
    drils_top DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nonref_single_ended_cfg(cfg), .out0Ready(evLvl[0]), .out1Ready(evLvl[1]),
        .adcReady(evLvl[3]), .timerTick(evLvl[2]), .analogSenseIn(senseIn),
        .analogSenseOut(senseOut), .analogSenseOe_b(senseOe_b), .hostIrqLines(lines),
        .dmaReqA(dmaA), .dmaReqB(dmaB), .irq(irq));
    drils_host host (.clock(clock), .rst_b(rst_b), .dmaReqA(dmaA), .dmaReqB(dmaB),
        .cntA(cntA), .cntB(cntB));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Look at the answer mid-cycle, away from the edge that launches it
        do @(negedge clock); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        perr = pslverr;
        // Request stands through the rising edge that samples pready high
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic fire(input logic [3:0] m);
        @(posedge clock);
        evLvl <= m;
        repeat (8) @(posedge clock);
        evLvl <= 4'h0;
        repeat (8) @(posedge clock);
    endtask : fire
    task automatic wrap_up;
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #2000000;
        errors++;
        wrap_up();
    end
    // ==========
    // Scenarios
    initial begin
        void'($urandom(94));
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        chk({irq, senseOe_b}, 32'h1);
        apb(1'b1, 8'h08, 32'hf);
        for (int i = 0; i < 8; i++) begin
            cmd = $urandom & 32'h30;
            ev = $urandom & 32'h3;
            apb(1'b1, 8'h00, cmd);
            fire(ev[3:0]);
            apb(1'b0, 8'h04, 32'h0);
            chk(rd, ev & (cmd >> 4));
            chk(irq, |(ev & (cmd >> 4)));
            apb(1'b1, 8'h0c, 32'hf);
        end
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h10);
        fire(4'h1);
        chk(irq, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 8'h08, 32'h1);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h00, 32'h10 | c);
            apb(1'b0, 8'h10, 32'h0);
            chk(rd, 32'h1 << lvMap[c]);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk(perr, 32'h1);
        apb(1'b1, 8'h0c, 32'h1);
        chk(irq, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, {28'h0, k[0], 3'h0});
            cfg <= k[1];
            repeat (8) @(posedge clock);
            chk(senseOe_b, !(k[0] && !k[1]));
        end
        cfg <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            exA = cntA + expA[j];
            exB = cntB + expB[j];
            apb(1'b1, 8'h00, (modes[j] << 8) | 32'h30);
            fire(4'h8);
            fire(4'h8);
            fire(4'h1);
            fire(4'h2);
            fire(4'h4);
            chk(cntA, exA);
            chk(cntB, exB);
            apb(1'b0, 8'h04, 32'h0);
            if (j == 0) chk(rd[2], 32'h1);
            apb(1'b1, 8'h0c, 32'hf);
        end
        wrap_up();
    end
endmodule : dac_request_irq_level_select_tb
`default_nettype wire
